// [rtl/smc_pkg.sv]
// Package: constants and types of the strap and miscellaneous pin control block
package smc_pkg;

  // ****************************************
  // Register map (byte offsets on APB)
  // ****************************************
  localparam logic [7:0] REG_GPIO_OE = 8'h00;
  localparam logic [7:0] REG_GPIO_OUT = 8'h04;
  localparam logic [7:0] REG_GPIO_IN = 8'h08;
  localparam logic [7:0] REG_STRAP = 8'h0C;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_EE_CMD = 8'h14;
  localparam logic [7:0] REG_EE_STAT = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EE_CMD_START_BIT = 8;
  localparam int EE_CMD_READ_BIT = 9;
  localparam int EE_STAT_BUSY_BIT = 0;
  localparam int EE_STAT_OFF_BIT = 1;
  localparam int EE_STAT_DATA_LSB = 8;
  localparam int CTRL_MGMT_BIT = 0;
  localparam int STRAP_ADDR_LSB = 5;
  localparam int STRAP_SEL_LSB = 8;
  localparam int STRAP_SCAN_BIT = 13;
  localparam int STRAP_DONE_BIT = 14;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] GPIO_OE_RST = 8'h00;
  localparam logic [7:0] GPIO_OUT_RST = 8'h00;
  localparam logic CTRL_MGMT_RST = 1'b1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int EE_HALF_NS = 500;
  localparam int EE_HALF_CYC = (EE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h3;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    EE_IDLE = 2'b00,
    EE_LOW = 2'b01,
    EE_HIGH = 2'b10
  } smc_ee_st_t;

  typedef struct packed {
    logic eeprom_load_en;
    logic power_save_en;
    logic status_mode;
    logic smbus_mode;
    logic debug_mode;
  } smc_straps_t;

  typedef struct packed {
    logic ee_sda;
    logic scan_in;
    logic mfg_test;
    logic [7:0] gpio;
    logic power_save;
    logic sub_sel;
    logic smbus_sel;
    logic debug_n;
    logic [2:0] clkreq_n;
  } smc_pins_t;

  typedef struct packed {
    logic start;
    logic read;
    logic [7:0] wdata;
  } smc_ee_req_t;

  typedef struct packed {
    logic busy;
    logic [7:0] rdata;
  } smc_ee_rsp_t;

endpackage

// [rtl/smc_sync.sv]
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module smc_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smc_sync_state_t;

  smc_sync_state_t q;
  smc_sync_state_t d;

  // ****************************************
  // Stage one feeds only stage two
  // ****************************************
  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule
`default_nettype wire

// [rtl/smc_ee_serial.sv]
// Byte-wide serial shifter for the EEPROM clock and data pins
`timescale 1ns/1ps
`default_nettype none
module smc_ee_serial (
  input wire logic pclk,
  input wire logic presetn,
  input wire smc_pkg::smc_ee_req_t req,
  input wire logic sda_in,
  output smc_pkg::smc_ee_rsp_t rsp,
  output logic sclk,
  output logic sda_o,
  output logic sda_oe_n
);
  import smc_pkg::*;
  localparam int CW = $clog2(EE_HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(EE_HALF_CYC - 1);

  typedef struct packed {
    smc_ee_st_t st;
    logic [CW-1:0] cnt;
    logic [2:0] bitn;
    logic read;
    logic [7:0] sh;
    logic sclk;
    logic sdo;
    logic oe_n;
  } smc_ee_state_t;

  smc_ee_state_t q;
  smc_ee_state_t d;

  // ****************************************
  // Bit timing: data changes while clock low
  // ****************************************
  always_comb begin
    d = q;
    unique case (q.st)
      EE_IDLE: begin
        if (req.start) begin
          d.st = EE_LOW;
          d.cnt = '0;
          d.bitn = '0;
          d.read = req.read;
          d.sh = req.wdata;
          d.sdo = req.wdata[7];
          d.oe_n = req.read;
          d.sclk = 1'b0;
        end
      end
      EE_LOW: begin
        if (q.cnt == LAST) begin
          d.cnt = '0;
          d.st = EE_HIGH;
          d.sclk = 1'b1;
          if (q.read) begin
            d.sh = {q.sh[6:0], sda_in};
          end
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
      EE_HIGH: begin
        if (q.cnt == LAST) begin
          d.cnt = '0;
          d.sclk = 1'b0;
          if (!q.read) begin
            d.sh = {q.sh[6:0], 1'b0};
          end
          if (q.bitn == 3'h7) begin
            d.st = EE_IDLE;
            d.oe_n = 1'b1;
          end else begin
            d.st = EE_LOW;
            d.bitn = q.bitn + 1'b1;
            d.sdo = q.sh[6];
          end
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
      default: begin
        d.st = EE_IDLE;
        d.oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: EE_IDLE, cnt: '0, bitn: '0, read: 1'b0, sh: '0, sclk: 1'b0, sdo: 1'b0, oe_n: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign rsp.busy = (q.st != EE_IDLE);
  assign rsp.rdata = q.sh;
  assign sclk = q.sclk;
  assign sda_o = q.sdo;
  assign sda_oe_n = q.oe_n;
endmodule
`default_nettype wire

// [rtl/smc_top.sv]
// Strap capture, miscellaneous pin control and APB register file
//
// Summary of operation
// - EEPROM data pin is sampled at init; high enables EEPROM loading.
// - After init, drive EEPROM clock and use data pin bidirectionally.
// - Scan control pin driven as zero output except in manufacturing test.
// - Each GPIO pin is input-only or bidirectional per enable register; GPIO 7 to 5 stay input while management is on, 4 to 0 in debug mode.
// - GPIO 7 to 5 give the low three management slave address bits.
// - In debug mode GPIO 4 to 0 form the debug selection code.
// - Power-save strap high enables power saving; low keeps it off.
// - Select strap low gives L1.1 substate; high gives port-status pins.
// - Protocol strap low selects I2C rules; high selects SMBus rules.
// - Debug strap low enters debug mode; high means normal operation.
// - In status mode, each shared pin reports its own port's status.
// - Released clock request stops refclk and PLL; asserted restores them.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module smc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic eeprom_serial_clock,
  input wire logic eeprom_serial_data_i,
  output logic eeprom_serial_data_o,
  output logic eeprom_serial_data_oe_n,
  input wire logic scan_enable_i,
  output logic scan_enable_o,
  output logic scan_enable_oe_n,
  input wire logic mfg_test_mode,
  input wire logic [7:0] gpio_i,
  output logic [7:0] gpio_o,
  output logic [7:0] gpio_oe_n,
  input wire logic power_save_strap,
  input wire logic substate_or_status_select,
  input wire logic smbus_select_strap,
  input wire logic debug_enable_strap,
  input wire logic [2:0] clock_request_n_i,
  output logic [2:0] clock_request_n_o,
  output logic [2:0] clock_request_n_oe_n,
  input wire logic [2:0] port_status_in,
  input wire logic [2:0] core_clock_wanted,
  output smc_pkg::smc_straps_t straps,
  output logic strap_valid,
  output logic [2:0] mgmt_addr_low,
  output logic [4:0] debug_select,
  output logic [2:0] refclk_pll_on
);
  import smc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0] init_cnt;
    logic init_done;
    smc_straps_t straps;
    logic [7:0] gpio_oe;
    logic [7:0] gpio_out;
    logic [7:0] gpio_in;
    logic mgmt_en;
    logic [2:0] mgmt_addr;
    logic [4:0] dbg_sel;
    logic scan_release;
    logic scan_in;
    logic [2:0] per_port_status_out;
    logic [2:0] ck_o;
    logic [2:0] ck_oe_n;
    logic [2:0] pll_on;
    logic [31:0] prdata;
    logic err;
    smc_ee_req_t ee_req;
  } smc_state_t;

  smc_state_t q;
  smc_state_t d;
  smc_pins_t pins_raw;
  smc_pins_t pins;
  smc_ee_rsp_t ee_rsp;
  logic ee_sclk;
  logic ee_sda_o;
  logic ee_sda_oe_n;
  logic setup;
  logic access_wr;
  logic [7:0] gpio_lock;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  assign pins_raw.ee_sda = eeprom_serial_data_i;
  assign pins_raw.scan_in = scan_enable_i;
  assign pins_raw.mfg_test = mfg_test_mode;
  assign pins_raw.gpio = gpio_i;
  assign pins_raw.power_save = power_save_strap;
  assign pins_raw.sub_sel = substate_or_status_select;
  assign pins_raw.smbus_sel = smbus_select_strap;
  assign pins_raw.debug_n = debug_enable_strap;
  assign pins_raw.clkreq_n = clock_request_n_i;

  smc_sync #(
    .W($bits(smc_pins_t))
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(pins_raw),
    .dout(pins)
  );

  // ****************************************
  // EEPROM serial engine
  // ****************************************
  smc_ee_serial u_ee (
    .pclk(pclk),
    .presetn(presetn),
    .req(q.ee_req),
    .sda_in(pins.ee_sda),
    .rsp(ee_rsp),
    .sclk(ee_sclk),
    .sda_o(ee_sda_o),
    .sda_oe_n(ee_sda_oe_n)
  );

  assign setup = psel & ~penable;
  assign access_wr = psel & penable & pwrite & ~q.err;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.ee_req.start = 1'b0;

    // Wait for the synchroniser to fill before trusting the straps
    if (!q.init_done) begin
      d.init_cnt = q.init_cnt + 1'b1;
      if (q.init_cnt == STRAP_SETTLE_CYC) begin
        d.init_done = 1'b1;
        d.straps.eeprom_load_en = pins.ee_sda;
        d.straps.power_save_en = pins.power_save;
        d.straps.status_mode = pins.sub_sel;
        d.straps.smbus_mode = pins.smbus_sel;
        d.straps.debug_mode = ~pins.debug_n;
      end
    end

    d.gpio_in = pins.gpio;
    d.scan_in = pins.scan_in;
    d.scan_release = pins.mfg_test;

    if (q.mgmt_en) begin
      d.mgmt_addr = pins.gpio[7:5];
    end else begin
      d.mgmt_addr = 3'h0;
    end

    if (q.straps.debug_mode) begin
      d.dbg_sel = pins.gpio[4:0];
    end else begin
      d.dbg_sel = 5'h00;
    end

    // Shared pins stay released until their function is known
    d.per_port_status_out = port_status_in;
    if (!q.init_done) begin
      d.ck_o = 3'h0;
      d.ck_oe_n = 3'h7;
      d.pll_on = 3'h7;
    end else if (q.straps.status_mode) begin
      d.ck_o = q.per_port_status_out;
      d.ck_oe_n = 3'h0;
      d.pll_on = 3'h7;
    end else begin
      // Open-drain request: pull low only while the core wants a clock
      d.ck_o = 3'h0;
      d.ck_oe_n = ~core_clock_wanted;
      d.pll_on = ~pins.clkreq_n;
    end

    // Read data and error are decided in the setup cycle
    if (setup) begin
      d.prdata = 32'h0000_0000;
      d.err = 1'b0;
      if (paddr == REG_GPIO_OE) begin
        d.prdata[7:0] = q.gpio_oe;
      end else if (paddr == REG_GPIO_OUT) begin
        d.prdata[7:0] = q.gpio_out;
      end else if (paddr == REG_GPIO_IN) begin
        d.prdata[7:0] = q.gpio_in;
      end else if (paddr == REG_STRAP) begin
        d.prdata[4:0] = q.straps;
        d.prdata[STRAP_ADDR_LSB +: 3] = q.mgmt_addr;
        d.prdata[STRAP_SEL_LSB +: 5] = q.dbg_sel;
        d.prdata[STRAP_SCAN_BIT] = q.scan_in;
        d.prdata[STRAP_DONE_BIT] = q.init_done;
      end else if (paddr == REG_CTRL) begin
        d.prdata[CTRL_MGMT_BIT] = q.mgmt_en;
      end else if (paddr == REG_EE_CMD) begin
        d.prdata[7:0] = q.ee_req.wdata;
        d.prdata[EE_CMD_READ_BIT] = q.ee_req.read;
      end else if (paddr == REG_EE_STAT) begin
        d.prdata[EE_STAT_BUSY_BIT] = ee_rsp.busy | q.ee_req.start;
        d.prdata[EE_STAT_OFF_BIT] = ~q.straps.eeprom_load_en;
        d.prdata[EE_STAT_DATA_LSB +: 8] = ee_rsp.rdata;
      end else begin
        d.err = 1'b1;
      end
    end

    // Writes take effect at the access edge
    if (access_wr) begin
      if (paddr == REG_GPIO_OE) begin
        d.gpio_oe = pwdata[7:0];
      end else if (paddr == REG_GPIO_OUT) begin
        d.gpio_out = pwdata[7:0];
      end else if (paddr == REG_CTRL) begin
        d.mgmt_en = pwdata[CTRL_MGMT_BIT];
      end else if (paddr == REG_EE_CMD) begin
        // A start while disabled or busy is dropped silently
        if (pwdata[EE_CMD_START_BIT] && q.init_done && q.straps.eeprom_load_en && !ee_rsp.busy) begin
          d.ee_req.start = 1'b1;
          d.ee_req.read = pwdata[EE_CMD_READ_BIT];
          d.ee_req.wdata = pwdata[7:0];
        end
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.gpio_oe <= GPIO_OE_RST;
      q.gpio_out <= GPIO_OUT_RST;
      q.mgmt_en <= CTRL_MGMT_RST;
      q.ck_oe_n <= 3'h7;
      q.pll_on <= 3'h7;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & q.err;

  // EEPROM data pin stays released and clock stays low during strap capture
  assign eeprom_serial_clock = ee_sclk;
  assign eeprom_serial_data_o = ee_sda_o;
  assign eeprom_serial_data_oe_n = ee_sda_oe_n | ~q.init_done;

  assign scan_enable_o = 1'b0;
  assign scan_enable_oe_n = q.scan_release;

  // Address and debug pins are forced to input while they carry straps
  assign gpio_lock = {{3{q.mgmt_en}}, {5{q.straps.debug_mode}}};
  assign gpio_o = q.gpio_out;
  assign gpio_oe_n = ~(q.gpio_oe & ~gpio_lock);

  assign clock_request_n_o = q.ck_o;
  assign clock_request_n_oe_n = q.ck_oe_n;

  assign straps = q.straps;
  assign strap_valid = q.init_done;
  assign mgmt_addr_low = q.mgmt_addr;
  assign debug_select = q.dbg_sel;
  assign refclk_pll_on = q.pll_on;
endmodule
`default_nettype wire

// [sim/smc_ee_model.sv]
// Behavioural serial EEPROM with its load-enable strap on the data pin
`timescale 1ns/1ps
`default_nettype none
module smc_ee_model #(
  parameter logic [7:0] RD = 8'hA5
) (
  input wire logic presetn,
  input wire logic sclk,
  input wire logic dev_o,
  input wire logic dev_oe_n,
  input wire logic strap_hi,
  input wire logic rd_en,
  output logic pin,
  output logic [7:0] got
);
  logic [7:0] sh = RD;
  // Undriven pin falls back to the board strap resistor level
  assign pin = !dev_oe_n ? dev_o : (presetn && rd_en ? sh[7] : strap_hi);
  always @(posedge sclk) if (!dev_oe_n) got <= {got[6:0], dev_o};
  // Change data while clock is low; rotate so a repeat read sees the same byte
  always @(negedge sclk) if (dev_oe_n && rd_en) sh <= {sh[6:0], sh[7]};
endmodule
`default_nettype wire

// [sim/smc_top_sva.sv]
// Port checker for the strap and pin control block
`timescale 1ns/1ps
`default_nettype none
module smc_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic eeprom_serial_clock,
  input wire logic eeprom_serial_data_i,
  input wire logic eeprom_serial_data_oe_n,
  input wire logic scan_enable_o,
  input wire logic scan_enable_oe_n,
  input wire logic mfg_test_mode,
  input wire logic [7:0] gpio_i,
  input wire logic [7:0] gpio_oe_n,
  input wire logic power_save_strap,
  input wire logic substate_or_status_select,
  input wire logic smbus_select_strap,
  input wire logic debug_enable_strap,
  input wire logic [2:0] clock_request_n_i,
  input wire logic [2:0] clock_request_n_o,
  input wire logic [2:0] clock_request_n_oe_n,
  input wire logic [2:0] port_status_in,
  input wire logic [2:0] core_clock_wanted,
  input wire smc_pkg::smc_straps_t straps,
  input wire logic strap_valid,
  input wire logic [2:0] mgmt_addr_low,
  input wire logic [4:0] debug_select,
  input wire logic [2:0] refclk_pll_on
);
  import smc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_strap_capture: assert property (
    $rose(strap_valid) |-> straps == {eeprom_serial_data_i, power_save_strap, substate_or_status_select,
    smbus_select_strap, !debug_enable_strap}) else $error("strap capture mismatch");
  a_strap_hold: assert property (
    $past(strap_valid) |-> strap_valid && $stable(straps)) else $error("straps moved");
  a_ee_quiet: assert property (
    !strap_valid || !straps.eeprom_load_en |-> !eeprom_serial_clock && eeprom_serial_data_oe_n)
    else $error("eeprom pins active");
  a_scan_low: assert property (
    scan_enable_oe_n == $past(mfg_test_mode, 3) && !scan_enable_o) else $error("scan pin wrong");
  a_gpio_oe_sw: assert property (
    $past(strap_valid, 2) && !$stable(gpio_oe_n) |-> $past(psel && penable && pwrite))
    else $error("gpio enable moved alone");
  a_pin_decode: assert property (
    ($stable(gpio_i) [*5]) ##0 $past(strap_valid, 4) |-> (mgmt_addr_low == gpio_i[7:5] || mgmt_addr_low == 3'h0)
    && debug_select == (straps.debug_mode ? gpio_i[4:0] : 5'h00)) else $error("gpio decode wrong");
  a_debug_lock: assert property (
    $past(strap_valid) && straps.debug_mode |-> &gpio_oe_n[4:0]) else $error("debug pins driven");
  a_status_pins: assert property (
    $past(strap_valid, 3) && straps.status_mode |-> clock_request_n_oe_n == 3'h0
    && clock_request_n_o == $past(port_status_in, 2)) else $error("status pins wrong");
  a_l1_request: assert property (
    $past(strap_valid, 2) && !straps.status_mode |-> clock_request_n_oe_n == ~$past(core_clock_wanted))
    else $error("clock request wrong");
  a_l1_refclk: assert property (
    ($stable(clock_request_n_i) [*5]) ##0 ($past(strap_valid, 5) && !straps.status_mode)
    |-> refclk_pll_on == ~clock_request_n_i) else $error("refclk state wrong");
  c_status: cover property ($rose(strap_valid) && straps.status_mode);
  c_ee_drive: cover property ($fell(eeprom_serial_data_oe_n));
  c_scan_free: cover property ($rose(scan_enable_oe_n));
endmodule
bind smc_top smc_top_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .eeprom_serial_clock,
  .eeprom_serial_data_i, .eeprom_serial_data_oe_n, .scan_enable_o, .scan_enable_oe_n, .mfg_test_mode, .gpio_i,
  .gpio_oe_n, .power_save_strap, .substate_or_status_select, .smbus_select_strap, .debug_enable_strap,
  .clock_request_n_i, .clock_request_n_o, .clock_request_n_oe_n, .port_status_in, .core_clock_wanted, .straps,
  .strap_valid, .mgmt_addr_low, .debug_select, .refclk_pll_on);
`default_nettype wire

// [sim/tb_strap_and_misc_pin_control.sv]
// Self-checking bench for strap capture and pin control
`timescale 1ns/1ps
`default_nettype none
module tb_strap_and_misc_pin_control;
  import smc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mfg_test_mode, strap_valid, ee_strap, rd_en;
  logic eeprom_serial_clock, eeprom_serial_data_i, eeprom_serial_data_o, eeprom_serial_data_oe_n;
  logic scan_enable_i, scan_enable_o, scan_enable_oe_n, power_save_strap, substate_or_status_select;
  logic smbus_select_strap, debug_enable_strap;
  logic [7:0] paddr, gpio_i, gpio_o, gpio_oe_n, gpio_ext, ee_got, wb, ob, en;
  logic [31:0] pwdata, prdata, r, sx;
  logic [2:0] clock_request_n_i, clock_request_n_o, clock_request_n_oe_n, port_status_in, core_clock_wanted;
  logic [2:0] mgmt_addr_low, refclk_pll_on, peer_n;
  logic [4:0] debug_select;
  logic [33:0] q[$];
  smc_straps_t straps;
  int n_mismatch = 0, n_checks = 0, seed = 32'h21111150, cyc = 0, k, i;
  // Undriven pins show the far side; the tester holds scan high when released
  assign gpio_i = (gpio_oe_n & gpio_ext) | (~gpio_oe_n & gpio_o);
  assign clock_request_n_i = (clock_request_n_oe_n & peer_n) | (~clock_request_n_oe_n & clock_request_n_o);
  assign scan_enable_i = scan_enable_oe_n ? 1'b1 : scan_enable_o;
  smc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .eeprom_serial_clock, .eeprom_serial_data_i, .eeprom_serial_data_o, .eeprom_serial_data_oe_n,
    .scan_enable_i, .scan_enable_o, .scan_enable_oe_n, .mfg_test_mode, .gpio_i, .gpio_o, .gpio_oe_n,
    .power_save_strap, .substate_or_status_select, .smbus_select_strap, .debug_enable_strap,
    .clock_request_n_i, .clock_request_n_o, .clock_request_n_oe_n, .port_status_in, .core_clock_wanted,
    .straps, .strap_valid, .mgmt_addr_low, .debug_select, .refclk_pll_on);
  smc_ee_model #(.RD(8'h5A)) ee (.presetn, .sclk(eeprom_serial_clock), .dev_o(eeprom_serial_data_o),
    .dev_oe_n(eeprom_serial_data_oe_n), .strap_hi(ee_strap), .rd_en, .pin(eeprom_serial_data_i), .got(ee_got));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    if (!w) q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, 32'h0, {1'b1, err, e});
  endtask
  task automatic ee_wait();
    int n;
    n = 0;
    repeat (3) @(posedge pclk);
    do begin
      apb(1'b0, REG_EE_STAT, 32'h0, 34'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 400);
    check({31'h0, r[0]}, 32'h0);
  endtask
  // Oldest read note is compared when its access phase completes, if its check bit is set; otherwise it is only dropped
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      if (q[0][33]) begin
        check(prdata, q[0][31:0]);
        check({31'h0, pslverr}, {31'h0, q[0][32]});
      end
      void'(q.pop_front());
    end
  end
  // ****************************************
  // Main sequence: normal mode, then debug plus status mode
  // ****************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, mfg_test_mode, rd_en} = '0;
    {ee_strap, power_save_strap, substate_or_status_select, smbus_select_strap, debug_enable_strap} = '0;
    {gpio_ext, peer_n, port_status_in, core_clock_wanted} = '0;
    for (k = 0; k < 2; k++) begin
      @(posedge pclk);
      r = $random(seed);
      presetn <= 1'b0;
      {ee_strap, substate_or_status_select, debug_enable_strap} <= {k == 0, k[0], !k[0]};
      {power_save_strap, smbus_select_strap, gpio_ext} <= r[9:0];
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      sx = {17'h0, 2'b10, k ? gpio_ext[4:0] : 5'h00, gpio_ext[7:5], ee_strap, power_save_strap,
        substate_or_status_select, smbus_select_strap, !debug_enable_strap};
      apb(1'b1, REG_STRAP, 32'hFFFFFFFF, 34'h0);
      rd(REG_STRAP, sx, 1'b0);
      rd(8'h1C, 32'h0, 1'b1);
      rd(8'h02, 32'h0, 1'b1);
      r = $random(seed);
      {wb, ob} = r[15:0];
      apb(1'b1, REG_GPIO_OE, {24'h0, wb}, 34'h0);
      apb(1'b1, REG_GPIO_OUT, {24'h0, ob}, 34'h0);
      rd(REG_GPIO_OUT, {24'h0, ob}, 1'b0);
      for (i = 1; i >= 0; i--) begin
        apb(1'b1, REG_CTRL, i, 34'h0);
        en = {i ? 3'h0 : 3'h7, k ? 5'h00 : 5'h1F};
        repeat (5) @(posedge pclk);
        check(gpio_oe_n, {~(wb & en)});
        rd(REG_GPIO_IN, {24'h0, (gpio_ext & ~(wb & en)) | (ob & wb & en)}, 1'b0);
      end
      if (k == 0) begin
        wb = r[23:16];
        apb(1'b1, REG_EE_CMD, {22'h0, 2'b01, wb}, 34'h0);
        ee_wait();
        check(ee_got, wb);
        rd_en <= 1'b1;
        apb(1'b1, REG_EE_CMD, 32'h300, 34'h0);
        ee_wait();
        rd_en <= 1'b0;
        rd(REG_EE_STAT, 32'h5A00, 1'b0);
      end else rd(REG_EE_STAT, 32'h2, 1'b0);
      repeat (3) begin
        r = $random(seed);
        {peer_n, port_status_in, core_clock_wanted} <= r[8:0];
        repeat (6) @(posedge pclk);
        check(k ? clock_request_n_o : refclk_pll_on, k ? port_status_in : {~clock_request_n_i});
        check(clock_request_n_oe_n, k ? 3'h0 : {~core_clock_wanted});
      end
      mfg_test_mode <= 1'b1;
      repeat (6) @(posedge pclk);
      check({scan_enable_oe_n, scan_enable_o}, 2'b10);
      mfg_test_mode <= 1'b0;
      repeat (6) @(posedge pclk);
      check({scan_enable_oe_n, scan_enable_o}, 2'b00);
      {power_save_strap, smbus_select_strap, debug_enable_strap} <= ~{power_save_strap, smbus_select_strap,
        debug_enable_strap};
      repeat (6) @(posedge pclk);
      rd(REG_STRAP, sx & 32'hFFFFFF1F, 1'b0);
    end
    repeat (5) @(posedge pclk);
    end_of_test();
  end
endmodule
`default_nettype wire
